// ==== hw/apb_bridge_write_protect.sv ====
// bus-to-peripheral bridge with one write protection unit per bridge region
// assumes a pipelined high-speed bus master and peripherals on the same clock
`timescale 1ns/100ps
module apb_bridge_write_protect (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        BRIDGE_CLK_EN,
   input  wire logic [2:0]  PWR_CLK_SET,
   input  wire logic [2:0]  PWR_CLK_CLR,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [3:0]  HPROT,
   input  wire logic [3:0]  HMASTER,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic      [31:0] HRDATA,
   output logic      [31:0] PADDR,
   output logic             PSEL,
   output logic             PENABLE,
   output logic             PWRITE,
   output logic      [31:0] PWDATA,
   output logic      [3:0]  PSTRB,
   output logic      [2:0]  PPROT,
   input  wire logic [31:0] PRDATA,
   input  wire logic        PREADY,
   input  wire logic        PSLVERR,
   output logic      [2:0]  UNIT_CLK_ON
);

   apb_wp_pkg::bridge_s s_reg;
   apb_wp_pkg::bridge_s s_next;

   logic [31:0]                         unit_prot [4];
   logic [apb_wp_pkg::NUM_UNITS-1:0]    unit_we;
   logic [1:0]                          bsel;
   logic [apb_wp_pkg::SLOT_W-1:0]       slot;
   logic                                mapped;
   logic                                is_unit;
   logic                                is_debug;
   logic                                prot_hit;
   logic                                blocked;
   logic [3:0]                          lanes;
   logic [31:0]                         lane_sel;
   logic                                accept;
   logic                                unit_on;

   assign bsel     = s_reg.addr[apb_wp_pkg::BRIDGE_LSB +: 2];
   assign slot     = s_reg.addr[apb_wp_pkg::SLOT_LSB +: apb_wp_pkg::SLOT_W];
   assign mapped   = (bsel != apb_wp_pkg::BRIDGE_NONE);
   assign is_unit  = (slot == apb_wp_pkg::UNIT_SLOT);
   assign is_debug = (s_reg.master == apb_wp_pkg::DEBUG_MASTER_ID);
   // only the unit of the addressed bridge is consulted
   assign prot_hit = mapped && unit_prot[bsel][slot];
   assign blocked  = s_reg.write && prot_hit && !is_debug;
   assign lanes    = apb_wp_pkg::lane_mask(s_reg.size, s_reg.addr[1:0]);
   assign lane_sel = apb_wp_pkg::lane_bits(lanes);
   assign unit_on  = mapped && s_reg.clk_on[bsel];
   // no transfer is taken while the bridge clock is gated
   assign accept   = BRIDGE_CLK_EN && HSEL && HTRANS[1] && HREADY;

   assign unit_prot[3] = 32'h00000000;

   genvar gi;
   generate
      for (gi = 0; gi < apb_wp_pkg::NUM_UNITS; gi++) begin : g_unit
         write_protect_unit #(
            .RESET_VAL  (apb_wp_pkg::UNIT_RESET[gi]),
            .VALID_MASK (apb_wp_pkg::UNIT_MASK[gi])
         ) u_unit (
            .clk       (CLK_SYS),
            .rst       (RST),
            .clk_en    (s_reg.clk_on[gi]),
            .clr_we    (unit_we[gi]),
            .clr_data  (HWDATA),
            .clr_lanes (lanes),
            .prot_bits (unit_prot[gi])
         );
      end
   endgenerate

   always_comb begin
      unit_we = '0;
      if (s_reg.fsm == apb_wp_pkg::ST_DATA && BRIDGE_CLK_EN && unit_on && is_unit && s_reg.write &&
          s_reg.addr[9:0] == apb_wp_pkg::PROTECT_CLEAR_OFS) begin
         unit_we = 3'h1 << bsel;
      end
   end

   always_comb begin
      s_next = s_reg;
      // power manager owns the unit clocks; a set beats a clear
      s_next.clk_on = (s_reg.clk_on & ~PWR_CLK_CLR) | PWR_CLK_SET;
      if (BRIDGE_CLK_EN) begin
         unique case (s_reg.fsm)
            apb_wp_pkg::ST_IDLE: begin
               s_next.hready = 1'b1;
               s_next.hresp  = 1'b0;
               if (accept) begin
                  s_next.fsm    = apb_wp_pkg::ST_DATA;
                  s_next.hready = 1'b0;
                  s_next.addr   = HADDR;
                  s_next.write  = HWRITE;
                  s_next.size   = HSIZE;
                  s_next.master = HMASTER;
                  s_next.pprot  = {~HPROT[0], 1'b0, HPROT[1]};
               end
            end
            apb_wp_pkg::ST_DATA: begin
               if (!mapped || blocked) begin
                  s_next.fsm   = apb_wp_pkg::ST_ERR;
                  s_next.hresp = 1'b1;
               end else if (is_unit) begin
                  s_next.fsm    = apb_wp_pkg::ST_IDLE;
                  s_next.hready = 1'b1;
                  s_next.hrdata = 32'h00000000;
                  if (unit_on && s_reg.addr[9:0] == apb_wp_pkg::PROTECT_CLEAR_OFS) begin
                     s_next.hrdata = unit_prot[bsel] & lane_sel;
                  end
               end else begin
                  // address and data go out together, enable with select
                  s_next.fsm     = apb_wp_pkg::ST_APB;
                  s_next.psel    = 1'b1;
                  s_next.penable = 1'b1;
                  s_next.pwdata  = HWDATA;
                  s_next.pstrb   = lanes;
               end
            end
            apb_wp_pkg::ST_APB: begin
               if (PREADY) begin
                  s_next.psel    = 1'b0;
                  s_next.penable = 1'b0;
                  s_next.pstrb   = 4'h0;
                  if (PSLVERR) begin
                     s_next.fsm   = apb_wp_pkg::ST_ERR;
                     s_next.hresp = 1'b1;
                  end else begin
                     s_next.fsm    = apb_wp_pkg::ST_IDLE;
                     s_next.hready = 1'b1;
                     s_next.hrdata = PRDATA & lane_sel;
                  end
               end
            end
            apb_wp_pkg::ST_ERR: begin
               // second error cycle: ready high, error still shown
               s_next.fsm    = apb_wp_pkg::ST_IDLE;
               s_next.hready = 1'b1;
               s_next.hresp  = 1'b1;
            end
         endcase
      end
      if (RST) begin
         s_next.fsm     = apb_wp_pkg::ST_IDLE;
         s_next.hready  = 1'b1;
         s_next.hresp   = 1'b0;
         s_next.hrdata  = 32'h00000000;
         s_next.addr    = 32'h00000000;
         s_next.write   = 1'b0;
         s_next.size    = 3'h0;
         s_next.master  = 4'h0;
         s_next.pprot   = 3'h0;
         s_next.psel    = 1'b0;
         s_next.penable = 1'b0;
         s_next.pwdata  = 32'h00000000;
         s_next.pstrb   = 4'h0;
         s_next.clk_on  = apb_wp_pkg::UNIT_CLK_RESET;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      s_reg <= s_next;
   end

   assign HREADYOUT   = s_reg.hready;
   assign HRESP       = s_reg.hresp;
   assign HRDATA      = s_reg.hrdata;
   assign PADDR       = s_reg.addr;
   assign PSEL        = s_reg.psel;
   assign PENABLE     = s_reg.penable;
   assign PWRITE      = s_reg.write;
   assign PWDATA      = s_reg.pwdata;
   assign PSTRB       = s_reg.pstrb;
   assign PPROT       = s_reg.pprot;
   assign UNIT_CLK_ON = s_reg.clk_on;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   logic data_go;
   assign data_go = (s_reg.fsm == apb_wp_pkg::ST_DATA) && BRIDGE_CLK_EN;
   logic [31:0] unit_view;
   logic        take;
   assign unit_view = unit_prot[bsel] & lane_sel;
   assign take      = (s_reg.fsm == apb_wp_pkg::ST_IDLE) && accept;

   AST_RESET_CLK: assert property ($past(RST) |-> (UNIT_CLK_ON == 3'h3))
      else $error("unit clocks wrong after reset");

   AST_OWN_UNIT: assert property ((unit_we != 3'h0) |->
      (mapped && (unit_we == (3'h1 << bsel)) && is_unit))
      else $error("clear reached a unit of another bridge");

   AST_PROT_ERR: assert property ((data_go && mapped && blocked) |=>
      (HRESP && !HREADYOUT && !PSEL) ##1 (HRESP && HREADYOUT && !PSEL))
      else $error("protected write not refused with two-cycle error");

   AST_DBG_BYPASS: assert property ((data_go && mapped && !is_unit && s_reg.write && is_debug) |=>
      (PSEL && PENABLE && PWRITE))
      else $error("debugger write did not reach the peripheral");

   AST_ROUTE: assert property ((data_go && mapped && !is_unit && !blocked) |=>
      (PSEL && PADDR == $past(s_reg.addr) && PWDATA == $past(HWDATA)))
      else $error("transfer not forwarded to peripheral bus");

   AST_MERGED: assert property ($rose(PSEL) |-> PENABLE)
      else $error("select without enable in the same cycle");

   AST_WAIT: assert property ((PSEL && !PREADY) |=>
      (PSEL && PENABLE && $stable(PADDR) && $stable(PWDATA) && !HREADYOUT))
      else $error("wait state not honoured");

   AST_SLVERR: assert property ((PSEL && PREADY && PSLVERR) |=>
      (HRESP && !HREADYOUT) ##1 (HRESP && HREADYOUT))
      else $error("peripheral error not passed to master");

   AST_STRB: assert property (PSEL |->
      (PSTRB == apb_wp_pkg::lane_mask(s_reg.size, PADDR[1:0])))
      else $error("lane strobes do not match size and address");

   AST_STALL: assert property ((!BRIDGE_CLK_EN && !RST) |=> $stable(s_reg.fsm))
      else $error("bridge moved while its clock was off");

   AST_ACCEPT_WAIT: assert property (take |=> (!HREADYOUT && !HRESP && !PSEL))
      else $error("accepted transfer did not open a data phase");

   AST_WRITE_HELD: assert property (take |=> (PWRITE == $past(HWRITE) && PADDR == $past(HADDR)))
      else $error("address phase not captured");

   AST_PPROT_MAP: assert property (take |=> (PPROT == {~$past(HPROT[0]), 1'b0, $past(HPROT[1])}))
      else $error("protection signalling not mapped");

   AST_UNMAPPED: assert property ((data_go && !mapped) |=> (HRESP && !HREADYOUT && !PSEL))
      else $error("unmapped access not refused");

   AST_UNIT_DONE: assert property ((data_go && mapped && is_unit) |=> (HREADYOUT && !HRESP && !PSEL))
      else $error("unit access left the bridge region");

   AST_UNIT_OFF_READ: assert property ((data_go && mapped && is_unit && !unit_on) |=> (HRDATA == 32'h0))
      else $error("unit with clock off returned data");

   AST_UNIT_READ: assert property ((data_go && is_unit && unit_on &&
      (s_reg.addr[9:0] == apb_wp_pkg::PROTECT_CLEAR_OFS)) |=> (HRDATA == $past(unit_view)))
      else $error("protect bits read back wrong");

   AST_CLEAR_ONLY_ON: assert property ((unit_we != 3'h0) |-> ((unit_we & s_reg.clk_on) == unit_we))
      else $error("clear reached a unit with its clock off");

   AST_DEBUG_OKAY: assert property ((data_go && mapped && !is_unit && is_debug) |=> (PSEL && !HRESP))
      else $error("debugger access refused");

   AST_READ_LANES: assert property ((PSEL && PREADY && !PSLVERR && BRIDGE_CLK_EN) |=>
      (HREADYOUT && !HRESP && !PSEL && ((HRDATA & ~$past(lane_sel)) == 32'h0)))
      else $error("read data outside enabled lanes");

   AST_SEL_IN_XFER: assert property (PSEL |-> (s_reg.fsm == apb_wp_pkg::ST_APB))
      else $error("select outside a peripheral transfer");

   AST_SEL_EN_PAIR: assert property (PSEL == PENABLE)
      else $error("select and enable apart");

   AST_DROP_CLEAN: assert property ($fell(PSEL) |-> (!PENABLE && PSTRB == 4'h0))
      else $error("strobes left up after transfer");

   AST_ERR_ONE_SHOT: assert property ((HRESP && HREADYOUT && BRIDGE_CLK_EN) |=> !HRESP)
      else $error("error response longer than two cycles");

   COV_PROT_ERR: cover property (data_go && mapped && blocked);
   COV_DBG_WRITE: cover property (PSEL && PWRITE && s_reg.master == apb_wp_pkg::DEBUG_MASTER_ID);
   COV_WAIT: cover property (PSEL && !PREADY ##1 PSEL && PREADY);
   COV_UNIT_CLEAR: cover property (unit_we != 3'h0);

endmodule : apb_bridge_write_protect

// ==== hw/apb_wp_pkg.sv ====
// package for the bridge with per-bridge write protection units
// assumes one 32-bit system clock and a synchronous reset
package apb_wp_pkg;

   localparam int NUM_UNITS = 3;

   // address layout of the bridge region
   localparam int BRIDGE_LSB = 16;
   localparam int SLOT_LSB   = 10;
   localparam int SLOT_W     = 5;
   localparam logic [1:0] BRIDGE_NONE = 2'h3;
   localparam logic [SLOT_W-1:0] UNIT_SLOT = 5'h00;
   localparam logic [9:0] PROTECT_CLEAR_OFS = 10'h000;

   // bus master code of the debugger
   localparam logic [3:0] DEBUG_MASTER_ID = 4'h1;

   localparam logic [2:0] SIZE_BYTE = 3'h0;
   localparam logic [2:0] SIZE_HALF = 3'h1;

   // unit bus clocks after reset: units 0 and 1 on, unit 2 off
   localparam logic [NUM_UNITS-1:0] UNIT_CLK_RESET = 3'h3;

   // protect_clear reset values and implemented bits, unit 0 first
   localparam logic [31:0] UNIT_RESET [NUM_UNITS] = '{32'h00000000, 32'h00000002, 32'h00000000};
   localparam logic [31:0] UNIT_MASK  [NUM_UNITS] = '{32'h0000007E, 32'h0000004E, 32'h0001FFFE};

   // bit positions inside protect_clear of unit 0
   localparam int EXT_IRQ_UNIT_PROTECT   = 6;
   localparam int RTC_PROTECT            = 5;
   localparam int WATCHDOG_PROTECT       = 4;
   localparam int GENERIC_CLOCK_PROTECT  = 3;
   localparam int SYSTEM_CONTROL_PROTECT = 2;
   localparam int POWER_MANAGER_PROTECT  = 1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DATA = 2'h1,
      ST_APB  = 2'h2,
      ST_ERR  = 2'h3
   } fsm_e;

   typedef struct packed {
      fsm_e                 fsm;
      logic                 hready;
      logic                 hresp;
      logic [31:0]          hrdata;
      logic [31:0]          addr;
      logic                 write;
      logic [2:0]           size;
      logic [3:0]           master;
      logic [2:0]           pprot;
      logic                 psel;
      logic                 penable;
      logic [31:0]          pwdata;
      logic [3:0]           pstrb;
      logic [NUM_UNITS-1:0] clk_on;
   } bridge_s;

   typedef struct packed {
      logic [31:0] prot;
   } unit_s;

   function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
      logic [3:0] m;
      m = 4'hF;
      if (size == SIZE_BYTE) begin
         m = 4'h1 << a;
      end else if (size == SIZE_HALF) begin
         m = a[1] ? 4'hC : 4'h3;
      end
      return m;
   endfunction : lane_mask

   function automatic logic [31:0] lane_bits(input logic [3:0] m);
      return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction : lane_bits

endpackage : apb_wp_pkg

// ==== hw/write_protect_unit.sv ====
// one write protection unit: holds the protect bits of one bridge
// assumes the clear strobe comes from the bridge on the same clock
`timescale 1ns/100ps
module write_protect_unit #(
   parameter logic [31:0] RESET_VAL  = 32'h00000000,
   parameter logic [31:0] VALID_MASK = 32'h00000000
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        clr_we,
   input  wire logic [31:0] clr_data,
   input  wire logic [3:0]  clr_lanes,
   output logic      [31:0] prot_bits
);

   apb_wp_pkg::unit_s s_reg;
   apb_wp_pkg::unit_s s_next;
   logic [31:0]       clr_bits;

   assign clr_bits = clr_data & VALID_MASK & apb_wp_pkg::lane_bits(clr_lanes);

   always_comb begin
      s_next = s_reg;
      if (rst) begin
         s_next.prot = RESET_VAL;
      end else if (clk_en && clr_we) begin
         // ones clear, zeros leave the bit alone; runs only when clk_en and clr_we are both high
         s_next.prot = s_reg.prot & ~clr_bits;
      end
   end

   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   assign prot_bits = s_reg.prot;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_ZERO_KEEPS: assert property ((clk_en && clr_we) |=>
      ((prot_bits & ~$past(clr_bits)) == ($past(prot_bits) & ~$past(clr_bits))))
      else $error("protect bit changed by a zero write");
   AST_ONE_CLEARS: assert property ((clk_en && clr_we && (clr_bits != 32'h0)) |=>
      ((prot_bits & $past(clr_bits)) == 32'h0))
      else $error("protect bit not cleared by a one write");
   AST_CLK_OFF_HOLD: assert property (!clk_en |=> $stable(prot_bits))
      else $error("protect bits moved while unit clock off");
   AST_BIT_MAP: assert property ((prot_bits & ~VALID_MASK) == 32'h0)
      else $error("protect bit outside implemented positions");
   COV_CLEAR: cover property (clk_en && clr_we && (clr_bits != 32'h0));

endmodule : write_protect_unit

// ==== verif/apb_bridge_write_protect_tb_top.sv ====
// self-checking bench: acts as the high-speed bus master, peripheral model on the far side
// assumes a single slave, so the bus ready input is the bridge's own ready output
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module apb_bridge_write_protect_tb_top;
   logic        CLK_SYS, RST, BRIDGE_CLK_EN, HSEL, HWRITE, HREADYOUT, HRESP, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [2:0]  PWR_CLK_SET, PWR_CLK_CLR, HSIZE, PPROT, UNIT_CLK_ON, prot_seen;
   logic [31:0] HADDR, HWDATA, HRDATA, PADDR, PWDATA, PRDATA, rd, pwd_seen, pad_seen;
   logic [1:0]  HTRANS;
   logic [3:0]  HPROT, HMASTER, PSTRB, wait_n, strb_seen;
   logic        err_en, rsp, psel_seen, pwr_seen;
   int          fails, total_checks, lat;

   apb_bridge_write_protect u_apb_bridge_write_protect (.CLK_SYS(CLK_SYS), .RST(RST), .BRIDGE_CLK_EN(BRIDGE_CLK_EN),
      .PWR_CLK_SET(PWR_CLK_SET), .PWR_CLK_CLR(PWR_CLK_CLR),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HPROT(HPROT), .HMASTER(HMASTER), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .HRDATA(HRDATA), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PPROT(PPROT), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .UNIT_CLK_ON(UNIT_CLK_ON));

   apb_periph_model u_apb_periph_model (.clk(CLK_SYS), .rst(RST), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
      .paddr(PADDR), .pwdata(PWDATA), .pstrb(PSTRB), .wait_n(wait_n), .err_en(err_en), .prdata(PRDATA),
      .pready(PREADY), .pslverr(PSLVERR));

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // one transfer; hold keeps the address phase up with the bridge clock gated first
   task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [2:0] sz, input logic [3:0] mst,
                           input logic [31:0] wd, input int hold);
      lat = 0;
      psel_seen = 1'b0;
      HSEL = 1'b1;
      HTRANS = 2'h2;
      HADDR = a;
      HWRITE = wr;
      HSIZE = sz;
      HMASTER = mst;
      repeat (hold) begin
         @(posedge CLK_SYS);
         #1;
         `CHK(PSEL, 1'b0);
         `CHK(HREADYOUT, 1'b1);
      end
      BRIDGE_CLK_EN = 1'b1;
      @(posedge CLK_SYS);
      #1;
      HSEL = 1'b0;
      HTRANS = 2'h0;
      HWDATA = wd;
      while (HREADYOUT !== 1'b1 && lat < 50) begin
         if (PSEL === 1'b1) begin
            psel_seen = 1'b1;
            `CHK(PENABLE, 1'b1);
            strb_seen = PSTRB;
            pwd_seen = PWDATA;
            pad_seen = PADDR;
            prot_seen = PPROT;
            pwr_seen = PWRITE;
         end
         @(posedge CLK_SYS);
         #1;
         lat++;
      end
      `CHK(lat < 50, 1'b1);
      rd = HRDATA;
      rsp = HRESP;
      if (rsp === 1'b1) begin
         @(posedge CLK_SYS);
         #1;
      end
   endtask : ahb_xfer

   task automatic t_reset();
      `CHK(UNIT_CLK_ON, 3'h3);
      ahb_xfer(32'h00000000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000000);
      ahb_xfer(32'h00010000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000002);
      ahb_xfer(32'h00020000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000000);
   endtask : t_reset

   task automatic t_unit_clock();
      PWR_CLK_CLR = 3'h2;
      @(posedge CLK_SYS);
      #1;
      PWR_CLK_CLR = 3'h0;
      `CHK(UNIT_CLK_ON, 3'h1);
      ahb_xfer(32'h00010000, 1'b1, 3'h2, 4'h0, 32'h00000002, 0);
      `CHK(rsp, 1'b0);
      PWR_CLK_SET = 3'h6;
      @(posedge CLK_SYS);
      #1;
      PWR_CLK_SET = 3'h0;
      `CHK(UNIT_CLK_ON, 3'h7);
      ahb_xfer(32'h00010000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000002);
   endtask : t_unit_clock

   task automatic t_protect();
      ahb_xfer(32'h00010400, 1'b1, 3'h2, 4'h0, 32'h12345678, 0);
      `CHK(rsp, 1'b1);
      `CHK(psel_seen, 1'b0);
      ahb_xfer(32'h00010400, 1'b1, 3'h2, 4'h1, 32'hCAFE0001, 0);
      `CHK(rsp, 1'b0);
      `CHK(psel_seen, 1'b1);
      `CHK(prot_seen, 3'h4);
      ahb_xfer(32'h00010400, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'hCAFE0001);
   endtask : t_protect

   task automatic t_clear();
      ahb_xfer(32'h00000000, 1'b1, 3'h2, 4'h0, 32'hFFFFFFFF, 0);
      ahb_xfer(32'h00010000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000002);
      ahb_xfer(32'h00010000, 1'b1, 3'h2, 4'h0, 32'h00000000, 0);
      ahb_xfer(32'h00010000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000002);
      ahb_xfer(32'h00010000, 1'b1, 3'h2, 4'h0, 32'h00000002, 0);
      ahb_xfer(32'h00010000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000000);
      ahb_xfer(32'h00010400, 1'b1, 3'h2, 4'h0, 32'h00000055, 0);
      `CHK(rsp, 1'b0);
      ahb_xfer(32'h00010400, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'h00000055);
   endtask : t_clear

   task automatic t_lanes();
      logic [31:0] wd;
      HPROT = 4'h3;
      ahb_xfer(32'h00000800, 1'b1, 3'h2, 4'h0, 32'h0, 0);
      `CHK(prot_seen, 3'h1);
      `CHK(pad_seen, 32'h00000800);
      `CHK(strb_seen, 4'hF);
      `CHK(pwr_seen, 1'b1);
      for (int i = 0; i < 4; i++) begin
         wd = 32'(8'h10 + i) << (8 * i);
         ahb_xfer(32'h00000800 + i, 1'b1, 3'h0, 4'h0, wd, 0);
         `CHK(strb_seen, 4'(4'h1 << i));
         `CHK(pwd_seen, wd);
      end
      ahb_xfer(32'h00000802, 1'b1, 3'h1, 4'h0, 32'hABCD0000, 0);
      `CHK(strb_seen, 4'hC);
      ahb_xfer(32'h00000800, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rd, 32'hABCD1110);
      ahb_xfer(32'h00000801, 1'b0, 3'h0, 4'h0, 32'h0, 0);
      `CHK(strb_seen, 4'h2);
      `CHK(rd, 32'h00001100);
      `CHK(pwr_seen, 1'b0);
   endtask : t_lanes

   task automatic t_wait_err();
      wait_n = 4'h3;
      ahb_xfer(32'h00020C00, 1'b1, 3'h2, 4'h0, 32'h00000077, 0);
      `CHK(lat, 5);
      wait_n = 4'h0;
      BRIDGE_CLK_EN = 1'b0;
      ahb_xfer(32'h00020C00, 1'b0, 3'h2, 4'h0, 32'h0, 4);
      `CHK(rd, 32'h00000077);
      err_en = 1'b1;
      ahb_xfer(32'h00020C00, 1'b1, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rsp, 1'b1);
      err_en = 1'b0;
      ahb_xfer(32'h00030000, 1'b0, 3'h2, 4'h0, 32'h0, 0);
      `CHK(rsp, 1'b1);
   endtask : t_wait_err

   initial begin
      CLK_SYS = 1'b0;
      forever #12.5 CLK_SYS = ~CLK_SYS;
   end

   initial begin
      #200000;
      $display("[ERR] %0t watchdog expired", $time);
      fails++;
      results();
   end

   initial begin
      {RST, BRIDGE_CLK_EN, HSEL, HWRITE, err_en} = 5'h10;
      {PWR_CLK_SET, PWR_CLK_CLR, HSIZE, HTRANS, HPROT, HMASTER, wait_n} = 23'h0;
      {HADDR, HWDATA} = 64'h0;
      fails = 0;
      total_checks = 0;
      repeat (8) @(posedge CLK_SYS);
      #1;
      RST = 1'b0;
      t_reset();
      t_unit_clock();
      t_protect();
      t_clear();
      t_lanes();
      t_wait_err();
      results();
   end
endmodule : apb_bridge_write_protect_tb_top

// ==== verif/apb_periph_model.sv ====
// peripheral-side model: a small register file behind the bridge, with wait states and error replies
// assumes the bridge is its only master and shares its clock
`timescale 1ns/100ps
module apb_periph_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic [3:0]  wait_n,
   input  wire logic        err_en,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   logic [31:0] mem [16];
   logic [3:0]  cnt;
   logic [3:0]  idx;
   assign idx     = {paddr[17:16], paddr[11:10]};
   assign pready  = psel & penable & (cnt == wait_n);
   assign pslverr = pready & err_en;
   // read data is a moving pattern until the reply is ready
   assign prdata  = pready ? mem[idx] : ({8{cnt}} ^ 32'hFFFF0000);
   always_ff @(posedge clk) begin
      if (rst || !(psel && penable) || pready) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
      if (pready && pwrite && !err_en) begin
         for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) begin
               mem[idx][8*i +: 8] <= pwdata[8*i +: 8];
            end
         end
      end
   end
endmodule : apb_periph_model
